//--- hdl/pmbcs_pkg.sv
// Shared constants for the PLL mode control and base clock selector block.
package pmbcs_pkg;

  // Register bus geometry.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Byte addresses of the three registers.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] BW_OFFSET   = 8'h04;
  localparam logic [7:0] PROG_OFFSET = 8'h08;

  // Register selector codes produced by the address decoder.
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_CTRL = 2'h1;
  localparam logic [1:0] SEL_BW   = 2'h2;
  localparam logic [1:0] SEL_PROG = 2'h3;

  // Control register field positions.
  localparam int unsigned CTRL_IE_BIT   = 7;
  localparam int unsigned CTRL_FLAG_BIT = 6;
  localparam int unsigned CTRL_LE_BIT   = 5;
  localparam int unsigned CTRL_BCS_BIT  = 4;
  localparam logic [3:0]  CTRL_LOW_READ = 4'hF;

  // Bandwidth control register field positions.
  localparam int unsigned BW_AUTO_BIT = 7;
  localparam int unsigned BW_LOCK_BIT = 6;
  localparam int unsigned BW_TRK_BIT  = 5;

  // Programming register field positions.
  localparam int unsigned PROG_N_MSB = 7;
  localparam int unsigned PROG_N_LSB = 4;
  localparam int unsigned PROG_L_MSB = 3;
  localparam int unsigned PROG_L_LSB = 0;

  // Values after reset.
  localparam logic       RST_IE   = 1'b0;
  localparam logic       RST_LE   = 1'b1;
  localparam logic       RST_BCS  = 1'b0;
  localparam logic       RST_AUTO = 1'b0;
  localparam logic       RST_TRK  = 1'b0;
  localparam logic [7:0] RST_PROG = 8'h00;

  // Positions of the sampled outside signals in the synchroniser vector.
  localparam int unsigned SYN_XTAL  = 0;
  localparam int unsigned SYN_VCO   = 1;
  localparam int unsigned SYN_LOCK  = 2;
  localparam int unsigned SYN_TRACK = 3;
  localparam int unsigned SYN_W     = 4;

  // Source edges that the transition control waits for on each clock.
  localparam logic [1:0] SWITCH_EDGES = 2'h3;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Clock switch states.
  typedef enum logic {
    PMBCS_SW_RUN,
    PMBCS_SW_WAIT
  } pmbcs_sw_state_e;

endpackage

//--- hdl/pmbcs_clk_switch.sv
// Glitch-free base clock switch with transition wait and divide by two.
`timescale 1ns/1ns
module pmbcs_clk_switch (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic xtal_rise,
  input  wire logic vco_rise,
  input  wire logic select_vco,
  output logic      base_clock_out
);

  pmbcs_pkg::pmbcs_sw_state_e state_reg;  // Running or waiting for edges.
  logic                       active_reg; // Source now driving the output.
  logic [1:0]                 xcnt_reg;   // Crystal edges seen in the wait.
  logic [1:0]                 vcnt_reg;   // VCO edges seen in the wait.

  // Rising edge of whichever source currently drives the divider.
  wire src_rise  = active_reg ? vco_rise : xtal_rise;
  // The wait ends once both sources have shown the required edges.
  wire wait_done = (xcnt_reg == pmbcs_pkg::SWITCH_EDGES) &&
                   (vcnt_reg == pmbcs_pkg::SWITCH_EDGES);

  // Transition control and output divider.  The VCO is never deselected
  // with the loop off, so its edges keep arriving during a wait.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg      <= pmbcs_pkg::PMBCS_SW_RUN;
      active_reg     <= 1'b0;
      xcnt_reg       <= 2'h0;
      vcnt_reg       <= 2'h0;
      base_clock_out <= 1'b0;
    end else begin
      case (state_reg)
        pmbcs_pkg::PMBCS_SW_RUN: begin
          if (select_vco != active_reg) begin
            state_reg <= pmbcs_pkg::PMBCS_SW_WAIT;
            xcnt_reg  <= 2'h0;
            vcnt_reg  <= 2'h0;
          end else if (src_rise) begin
            base_clock_out <= ~base_clock_out;
          end
        end
        pmbcs_pkg::PMBCS_SW_WAIT: begin
          if (xtal_rise && (xcnt_reg != pmbcs_pkg::SWITCH_EDGES)) begin
            xcnt_reg <= xcnt_reg + 2'h1;
          end
          if (vco_rise && (vcnt_reg != pmbcs_pkg::SWITCH_EDGES)) begin
            vcnt_reg <= vcnt_reg + 2'h1;
          end
          if (wait_done) begin
            active_reg <= select_vco;
            state_reg  <= pmbcs_pkg::PMBCS_SW_RUN;
          end
        end
        default: begin
          state_reg <= pmbcs_pkg::PMBCS_SW_RUN;
        end
      endcase
    end
  end

endmodule

//--- hdl/pmbcs_top.sv
// PLL mode control, lock indication and base clock selection with AXI4-Lite.
//
// Summary of operation
// - Acquisition mode reads tracking select clear.
// - Tracking whenever not acquiring or bit set.
// - Hardware control lets lock detector switch modes.
// - Auto: tracking bit read-only, follows tracking tolerance.
// - Auto: lock bit read-only, follows lock tolerance.
// - Enabled interrupt requested on each lock toggle.
// - Manual: tracking select writable, chooses filter.
// - Manual: lock indicator and interrupts disabled.
// - Feedback clock is VCO divided by N.
// - Program register: N high nibble, L low.
// - N of zero behaves as one.
// - L zero disables loop, forces crystal.
// - Switch waits three edges each, output static.
// - Switch output divided by two, even duty.
// - Select bit clear crystal, set VCO.
// - No VCO with loop off; no off with VCO.
// - Loop enable and select change need separate writes.
// - Program register ignores writes while loop enabled.
// - Reading control register clears lock change flag.
// - Reset sets loop enable.
// - Reset and stop clear base clock select.
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module pmbcs_top (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // AXI4-Lite write address channel.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Clock pins and behavioural analog indications.
  input  wire logic        crystal_clock,
  input  wire logic        vco_clock,
  input  wire logic        vco_in_lock,
  input  wire logic        vco_in_track,
  input  wire logic        stop_req,
  // Clock outputs and analog controls.
  output logic             base_clock_out,
  output logic             final_reference_clock,
  output logic             vco_feedback_clock,
  output logic             loop_active,
  output logic             tracking_mode,
  output logic             lock_change_irq
);

  // Map a byte address onto one of the three registers, or none.
  function automatic logic [1:0] decode_sel(input logic [7:0] addr);
    logic [1:0] sel;
    sel = pmbcs_pkg::SEL_NONE;
    if (addr == pmbcs_pkg::CTRL_OFFSET) begin
      sel = pmbcs_pkg::SEL_CTRL;
    end else if (addr == pmbcs_pkg::BW_OFFSET) begin
      sel = pmbcs_pkg::SEL_BW;
    end else if (addr == pmbcs_pkg::PROG_OFFSET) begin
      sel = pmbcs_pkg::SEL_PROG;
    end
    return sel;
  endfunction

  // Synchroniser stages for everything arriving from outside the domain.
  logic [pmbcs_pkg::SYN_W-1:0] sync1_reg;  // First stage, read by stage two.
  logic [pmbcs_pkg::SYN_W-1:0] sync2_reg;  // Second stage, safe to use.
  logic [pmbcs_pkg::SYN_W-1:0] prev_reg;   // Delayed copy for edge finding.

  // Bus slave state.
  logic        aw_held_reg;   // Write address captured, not yet used.
  logic        w_held_reg;    // Write data captured, not yet used.
  logic [7:0]  awaddr_q_reg;  // Captured write address.
  logic [31:0] wdata_q_reg;   // Captured write data.
  logic        wstrb0_q_reg;  // Captured strobe of the only live byte lane.
  logic        awready_reg;   // Registered write address ready.
  logic        wready_reg;    // Registered write data ready.
  logic        bvalid_reg;    // Write response pending.
  logic [1:0]  bresp_reg;     // Write response code.
  logic        arready_reg;   // Registered read address ready.
  logic        rvalid_reg;    // Read data pending.
  logic [31:0] rdata_reg;     // Read data.
  logic [1:0]  rresp_reg;     // Read response code.

  // Register file bits.
  logic        ie_reg;        // Lock change interrupt enable.
  logic        flag_reg;      // Lock change flag.
  logic        le_reg;        // Loop enable.
  logic        bcs_reg;       // Base clock select.
  logic        auto_reg;      // Hardware bandwidth control.
  logic        lock_reg;      // Lock indicator.
  logic        trk_reg;       // Tracking select.
  logic [7:0]  prog_reg;      // Feedback and range multipliers.

  // Feedback divider and output flops.
  logic [3:0]  fb_cnt_reg;    // VCO edges within one feedback period.
  logic        fb_reg;        // Feedback clock level.
  logic        ref_reg;       // Buffered reference clock.
  logic        loop_reg;      // Loop really running.
  logic        trkmode_reg;   // Filter in tracking mode.
  logic        irq_reg;       // Interrupt request.

  // Edges of the sampled clocks and the current analog indications.
  wire xtal_rise = sync2_reg[pmbcs_pkg::SYN_XTAL] &
                   ~prev_reg[pmbcs_pkg::SYN_XTAL];
  wire vco_rise  = sync2_reg[pmbcs_pkg::SYN_VCO] &
                   ~prev_reg[pmbcs_pkg::SYN_VCO];
  wire in_lock   = sync2_reg[pmbcs_pkg::SYN_LOCK];
  wire in_track  = sync2_reg[pmbcs_pkg::SYN_TRACK];

  // Bus handshakes and decode.  A write is done only when both halves
  // are held and no response is waiting, so readys fall one cycle later.
  wire       aw_take  = s_axi_awvalid & awready_reg;
  wire       w_take   = s_axi_wvalid & wready_reg;
  wire       ar_take  = s_axi_arvalid & arready_reg;
  wire       do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire [1:0] wsel     = decode_sel(awaddr_q_reg);
  wire [1:0] rsel     = decode_sel(s_axi_araddr);
  wire       wr_ok    = do_write & wstrb0_q_reg;
  wire       ctrl_wr  = wr_ok & (wsel == pmbcs_pkg::SEL_CTRL);
  wire       bw_wr    = wr_ok & (wsel == pmbcs_pkg::SEL_BW);
  wire       prog_wr  = wr_ok & (wsel == pmbcs_pkg::SEL_PROG);
  wire       ctrl_rd  = ar_take & (rsel == pmbcs_pkg::SEL_CTRL);
  wire [7:0] wd       = wdata_q_reg[7:0];

  // Next state of the bus slave.
  wire aw_held_next = aw_take | (aw_held_reg & ~do_write);
  wire w_held_next  = w_take | (w_held_reg & ~do_write);
  wire bvalid_next  = do_write | (bvalid_reg & ~s_axi_bready);
  wire rvalid_next  = ar_take | (rvalid_reg & ~s_axi_rready);
  wire [1:0] bresp_next = (wsel == pmbcs_pkg::SEL_NONE) ?
                          pmbcs_pkg::RESP_SLVERR : pmbcs_pkg::RESP_OKAY;
  wire [1:0] rresp_next = (rsel == pmbcs_pkg::SEL_NONE) ?
                          pmbcs_pkg::RESP_SLVERR : pmbcs_pkg::RESP_OKAY;

  // Programmed multipliers.
  // N high nibble, L low
  wire [3:0] mul_n = prog_reg[pmbcs_pkg::PROG_N_MSB:pmbcs_pkg::PROG_N_LSB];
  wire [3:0] mul_l = prog_reg[pmbcs_pkg::PROG_L_MSB:pmbcs_pkg::PROG_L_LSB];
  wire [3:0] n_eff = (mul_n == 4'h0) ? 4'h1 : mul_n;
  wire       l_nz  = (mul_l != 4'h0);

  // Interrupt enable is only writable, and only reads set, in auto mode.
  wire ie_next = auto_reg & (ctrl_wr ? wd[pmbcs_pkg::CTRL_IE_BIT] : ie_reg);

  wire wd_le      = wd[pmbcs_pkg::CTRL_LE_BIT];
  wire le_next    = (ctrl_wr & ~bcs_reg) ? wd_le : le_reg;
  wire le_req_chg = ctrl_wr & (wd_le != le_reg);
  wire bcs_wr     = (ctrl_wr & ~le_req_chg) ?
                    wd[pmbcs_pkg::CTRL_BCS_BIT] : bcs_reg;
  // zero L forces crystal; stop clears select
  wire bcs_next   = bcs_wr & le_reg & le_next & l_nz & ~stop_req;

  // lock follows detector in auto; disabled in manual
  wire lock_next  = auto_reg & in_lock;
  wire lock_tgl   = auto_reg & (lock_next != lock_reg);
  // toggle sets flag; read clears, set wins
  wire flag_next  = auto_reg & (lock_tgl | (flag_reg & ~ctrl_rd));
  wire auto_next  = bw_wr ? wd[pmbcs_pkg::BW_AUTO_BIT] : auto_reg;
  // auto: tracking follows detector; manual: software
  wire trk_next   = auto_reg ? in_track :
                    (bw_wr ? wd[pmbcs_pkg::BW_TRK_BIT] : trk_reg);
  wire [7:0] prog_next = (prog_wr & ~le_reg) ? wd : prog_reg;

  wire loop_next  = le_next & l_nz;

  wire       fb_wrap     = (fb_cnt_reg >= (n_eff - 4'h1));
  wire [3:0] fb_cnt_next = ~loop_reg ? 4'h0 :
                           (vco_rise ? (fb_wrap ? 4'h0 :
                           fb_cnt_reg + 4'h1) : fb_cnt_reg);
  wire [3:0] fb_half     = 4'((5'(n_eff) + 5'h01) >> 1);
  wire       fb_next     = ~loop_reg ? 1'b0 :
                           ((n_eff == 4'h1) ?
                           sync2_reg[pmbcs_pkg::SYN_VCO] :
                           (fb_cnt_next < fb_half));

  // Read data; unused control bits read as ones, others as zeros.
  wire [7:0] ctrl_view = {ie_reg, flag_reg, le_reg, bcs_reg,
                          pmbcs_pkg::CTRL_LOW_READ};
  wire [7:0] bw_view   = {auto_reg, lock_reg, trk_reg, 5'h00};
  wire [7:0] rd_byte   = (rsel == pmbcs_pkg::SEL_CTRL) ? ctrl_view :
                         (rsel == pmbcs_pkg::SEL_BW)   ? bw_view   :
                         (rsel == pmbcs_pkg::SEL_PROG) ? prog_reg  :
                         8'h00;

  // Two flops before any logic looks at the clock, lock and track pins, plus an edge stage.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg  <= 4'h0;
    end else begin
      sync1_reg <= {vco_in_track, vco_in_lock, vco_clock, crystal_clock};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Write channel handshakes, held flags and the write response.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awready_reg  <= 1'b0;
      wready_reg   <= 1'b0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= 2'h0;
    end else begin
      aw_held_reg  <= aw_held_next;
      w_held_reg   <= w_held_next;
      awready_reg  <= ~aw_held_next;
      wready_reg   <= ~w_held_next;
      bvalid_reg   <= bvalid_next;
      if (do_write) begin
        bresp_reg <= bresp_next;
      end
    end
  end

  // Payload capture has no reset need beyond a defined start value.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      awaddr_q_reg <= 8'h00;
      wdata_q_reg  <= 32'h00000000;
      wstrb0_q_reg <= 1'b0;
    end else begin
      if (aw_take) begin
        awaddr_q_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q_reg  <= s_axi_wdata;
        wstrb0_q_reg <= s_axi_wstrb[0];
      end
    end
  end

  // Read channel: data is sampled in the address cycle, so a read of the
  // control register and the flag clear refer to the same moment.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= 2'h0;
    end else begin
      arready_reg <= ~rvalid_next;
      rvalid_reg  <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= {24'h000000, rd_byte};
        rresp_reg <= rresp_next;
      end
    end
  end

  // Control, status and programming registers.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ie_reg   <= pmbcs_pkg::RST_IE;
      flag_reg <= 1'b0;
      le_reg   <= pmbcs_pkg::RST_LE;
      bcs_reg  <= pmbcs_pkg::RST_BCS;
      auto_reg <= pmbcs_pkg::RST_AUTO;
      lock_reg <= 1'b0;
      trk_reg  <= pmbcs_pkg::RST_TRK;
      prog_reg <= pmbcs_pkg::RST_PROG;
    end else begin
      ie_reg   <= ie_next;
      flag_reg <= flag_next;
      le_reg   <= le_next;
      bcs_reg  <= bcs_next;
      auto_reg <= auto_next;
      lock_reg <= lock_next;
      trk_reg  <= trk_next;
      prog_reg <= prog_next;
    end
  end

  // Feedback divider, reference buffer and analog control outputs.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fb_cnt_reg  <= 4'h0;
      fb_reg      <= 1'b0;
      ref_reg     <= 1'b0;
      loop_reg    <= 1'b0;
      trkmode_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      fb_cnt_reg  <= fb_cnt_next;
      fb_reg      <= fb_next;
      ref_reg     <= sync2_reg[pmbcs_pkg::SYN_XTAL];
      loop_reg    <= loop_next;
      // tracking when bit set; auto by detector
      trkmode_reg <= trk_next;
      irq_reg     <= flag_next & ie_next;
    end
  end

  // The switch sees the select bit only after its loop and range checks.
  pmbcs_clk_switch u_switch (
    .core_clk       (core_clk),
    .nrst           (nrst),
    .xtal_rise      (xtal_rise),
    .vco_rise       (vco_rise),
    .select_vco     (bcs_reg),
    .base_clock_out (base_clock_out)
  );

  // Bus and pin outputs, each straight from a flop.
  assign s_axi_awready         = awready_reg;
  assign s_axi_wready          = wready_reg;
  assign s_axi_bvalid          = bvalid_reg;
  assign s_axi_bresp           = bresp_reg;
  assign s_axi_arready         = arready_reg;
  assign s_axi_rvalid          = rvalid_reg;
  assign s_axi_rdata           = rdata_reg;
  assign s_axi_rresp           = rresp_reg;
  assign final_reference_clock = ref_reg;
  assign vco_feedback_clock    = fb_reg;
  assign loop_active           = loop_reg;
  assign tracking_mode         = trkmode_reg;
  assign lock_change_irq       = irq_reg;

endmodule

//--- testbench/pmbcs_properties.sv
// Port-level assertions for the PLL mode and base clock block.
`timescale 1ns/1ns
module pmbcs_properties (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        crystal_clock,
  input wire logic        base_clock_out,
  input wire logic        final_reference_clock,
  input wire logic        vco_feedback_clock,
  input wire logic        loop_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Cycles since reset; keeps $past from looking back into reset.
  logic [2:0] up_reg;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) up_reg <= 3'h0;
    else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
  end
  a_ref_follow: assert property (
    up_reg == 3'h7 |-> final_reference_clock == $past(crystal_clock, 3))
    else $error("reference clock does not trail the crystal");
  a_fb_off: assert property (
    !loop_active && !$past(loop_active) |-> !vco_feedback_clock)
    else $error("feedback clock runs with the loop off");
  a_base_static: assert property (
    $changed(base_clock_out) |=> $stable(base_clock_out)[*3])
    else $error("base clock toggles faster than its source");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_b_drop: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write response dropped early");
  a_r_drop: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read data dropped early");
  a_rdata_byte: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above the byte is not zero");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_loop_on: cover property ($rose(loop_active));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind pmbcs_top pmbcs_properties pmbcs_properties_inst (.*);

//--- testbench/pmbcs_sim_model.sv
// Behavioural system side: stop request and base clock edge meter.
`timescale 1ns/1ns
module pmbcs_sim_model (
  input  wire logic   core_clk,
  input  wire logic   nrst,
  input  wire logic   base_clock_out,
  input  wire logic   stop_cmd,
  output logic        stop_req,
  output logic [15:0] edge_count
);
  logic last_reg; // Base clock level at the previous edge.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stop_req <= 1'b0;
      last_reg <= 1'b0;
      edge_count <= 16'h0;
    end else begin
      stop_req <= stop_cmd;
      last_reg <= base_clock_out;
      if (last_reg != base_clock_out) edge_count <= edge_count + 16'h1;
    end
  end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the PLL mode and base clock block.
`timescale 1ns/1ns
module tb;
  localparam logic [7:0] CT = pmbcs_pkg::CTRL_OFFSET;
  localparam logic [7:0] BW = pmbcs_pkg::BW_OFFSET;
  localparam logic [7:0] PG = pmbcs_pkg::PROG_OFFSET;
  localparam logic [1:0] OK = pmbcs_pkg::RESP_OKAY;
  localparam logic [1:0] ER = pmbcs_pkg::RESP_SLVERR;
  localparam int         XE = 40000 / 700;  // Crystal rises per window.
  localparam int         VE = 40000 / 1100; // VCO rises per window.
  logic        core_clk, nrst, crystal_clock, vco_clock, vco_in_lock;
  logic        vco_in_track, stop_cmd, stop_req, base_clock_out, fb_q;
  logic        final_reference_clock, vco_feedback_clock, loop_active;
  logic        tracking_mode, lock_change_irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] edge_count;
  int          fb_cnt, compares, miscompares;
  pmbcs_top pmbcs_top_inst (.*);
  pmbcs_sim_model pmbcs_sim_model_inst (.core_clk(core_clk), .nrst(nrst),
    .base_clock_out(base_clock_out), .stop_cmd(stop_cmd),
    .stop_req(stop_req), .edge_count(edge_count));
  always #50 core_clk = ~core_clk;
  // Source clocks are slow and off the core edges, as the sampler needs.
  initial begin
    #17;
    forever #350 crystal_clock = ~crystal_clock;
  end
  initial begin
    #29;
    forever #550 vco_clock = ~vco_clock;
  end
  // Rising edges of the feedback clock, for the divider checks.
  always @(posedge core_clk) begin
    fb_q <= vco_feedback_clock;
    if (vco_feedback_clock === 1'b1 && fb_q === 1'b0) fb_cnt++;
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic flag(input string n, input logic e, g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  // Edge counts are compared with a small margin for phase.
  task automatic near(input string n, input int e, input logic [15:0] g);
    compares++;
    if ((g + 2 >= e && g <= e + 2) !== 1'b1) begin
      miscompares++;
      $display("unexpected %s: expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic meter(input int fe, input int be);
    int          f0;
    logic [15:0] b0;
    f0 = fb_cnt;
    b0 = edge_count;
    repeat (400) @(posedge core_clk);
    near("feedback rises", fe, 16'(fb_cnt - f0));
    near("base toggles", be, edge_count - b0);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #3000000;
    miscompares++;
    end_of_test;
  end
  initial begin
    {core_clk, crystal_clock, vco_clock, nrst, stop_cmd} = 5'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, vco_in_lock, vco_in_track} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {fb_cnt, compares, miscompares} = 96'h0;
    settle(3);
    nrst <= 1'b1;
    settle(2);
    rd(CT, 32'h2F, OK);
    rd(BW, 32'h00, OK);
    rd(8'h0C, 32'h00, ER);
    wr(8'h0C, 32'h00, ER);
    wr(PG, 32'h31, OK);
    rd(PG, 32'h00, OK);
    wr(CT, 32'h30, OK);
    rd(CT, 32'h2F, OK);
    meter(0, XE);
    $display("test reset done");
    wr(CT, 32'h00, OK);
    rd(CT, 32'h0F, OK);
    wr(PG, 32'h01, OK);
    rd(PG, 32'h01, OK);
    wr(CT, 32'h30, OK);
    rd(CT, 32'h2F, OK);
    flag("loop_active", 1'b1, loop_active);
    meter(VE, XE);
    $display("test program done");
    wr(CT, 32'h30, OK);
    rd(CT, 32'h3F, OK);
    settle(30);
    meter(VE, VE);
    wr(CT, 32'h00, OK);
    rd(CT, 32'h3F, OK);
    wr(CT, 32'h30, OK);
    stop_cmd <= 1'b1;
    settle(3);
    rd(CT, 32'h2F, OK);
    stop_cmd <= 1'b0;
    wr(CT, 32'h00, OK);
    wr(PG, 32'h31, OK);
    wr(CT, 32'h20, OK);
    // The switch back to the crystal can take over thirty cycles.
    settle(40);
    meter(VE / 3, XE);
    $display("test select done");
    wr(BW, 32'h80, OK);
    wr(CT, 32'hA0, OK);
    rd(CT, 32'hAF, OK);
    vco_in_lock <= 1'b1;
    settle(8);
    flag("irq", 1'b1, lock_change_irq);
    rd(BW, 32'hC0, OK);
    rd(CT, 32'hEF, OK);
    settle(2);
    flag("irq", 1'b0, lock_change_irq);
    rd(CT, 32'hAF, OK);
    vco_in_track <= 1'b1;
    wr(BW, 32'h80, OK);
    rd(BW, 32'hE0, OK);
    flag("tracking", 1'b1, tracking_mode);
    wr(CT, 32'h20, OK);
    {vco_in_lock, vco_in_track} <= 2'h0;
    settle(8);
    flag("irq", 1'b0, lock_change_irq);
    rd(CT, 32'h6F, OK);
    $display("test auto done");
    wr(BW, 32'h00, OK);
    vco_in_lock <= 1'b1;
    rd(BW, 32'h00, OK);
    flag("tracking", 1'b0, tracking_mode);
    wr(CT, 32'hA0, OK);
    rd(CT, 32'h2F, OK);
    flag("irq", 1'b0, lock_change_irq);
    wr(BW, 32'h20, OK);
    rd(BW, 32'h20, OK);
    flag("tracking", 1'b1, tracking_mode);
    $display("test manual done");
    end_of_test;
  end
endmodule
